// [ccc_clock_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module ccc_clock_ctrl
  import ccc_pkg::*;
#(
  parameter logic [2:0] STARTUP_SRC0 = SRC_RC_DIV,
  parameter logic [2:0] STARTUP_SRC1 = SRC_RC_DIV,
  parameter bit         TWO_SPEED0   = 1'b0,
  parameter bit         TWO_SPEED1   = 1'b0,
  parameter int         PRI_FREQ     = PRI_KHZ
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // peripheral clock requests, one per core
  input  wire logic [1:0]  periph_clk_req,
  // core clocks
  output logic      [1:0]  core_instr_tick,
  output logic      [1:0]  core_run,
  // oscillator output pin
  output logic             osc_output_pin_o,
  output logic             osc_output_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] ctrl_r [2];
  logic [31:0] ctrl_nxt [2];
  logic [31:0] pll_r [2];
  logic [31:0] pll_nxt [2];
  logic [31:0] aux_r [2];
  logic [31:0] aux_nxt [2];
  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [31:0] trim_r;
  logic [31:0] trim_nxt;
  logic        awready_r, awready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  tick_r, tick_nxt;
  logic [1:0]  run_r, run_nxt;
  logic        pin_r, pin_nxt;
  logic        oe_r, oe_nxt;
  logic [1:0]  switch_set;
  logic [2:0]  cur_src [2];
  logic [2:0]  pll_ref_src [2];
  logic [1:0]  switch_flag;
  logic [1:0]  pll_en;
  logic [1:0]  run_ok;
  logic [1:0]  pll_lock;
  logic [1:0]  aux_lock;
  logic [31:0] vco_khz [2];
  logic [31:0] pll_khz [2];
  logic [31:0] aux_vco_khz [2];
  logic [31:0] aux_khz [2];
  logic [31:0] pll_ref_khz [2];
  logic [31:0] fosc_khz [2];
  logic [31:0] rc_khz;
  logic [31:0] trim_ext;
  logic [31:0] pri_khz;
  logic        pri_ok;
  logic        crystal;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  strb,
                                         input logic [31:0] mask);
    logic [31:0] be;
    be     = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    wmerge = (old & ~(be & mask)) | (d & be & mask);
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // shared oscillators
  always_comb
  begin
    trim_ext = {{26{trim_r[5]}}, trim_r[5:0]};
    rc_khz   = 32'(RC_KHZ) + 32'(trim_ext * 32'(TRIM_STEP_KHZ));
    pri_khz  = (mode_r[1:0] == MODE_OFF) ? 32'h0000_0000 : 32'(PRI_FREQ);
    crystal  = mode_r[1:0] == MODE_MED_XTAL || mode_r[1:0] == MODE_HIGH_XTAL;
    case (mode_r[1:0])
      MODE_MED_XTAL:   pri_ok = PRI_FREQ >= MED_MIN_KHZ
                             && PRI_FREQ <= MED_MAX_KHZ;
      MODE_HIGH_XTAL:  pri_ok = PRI_FREQ >= HIGH_MIN_KHZ
                             && PRI_FREQ <= HIGH_MAX_KHZ;
      MODE_EXT_BYPASS: pri_ok = PRI_FREQ <= EXT_MAX_KHZ;
      default:         pri_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-core synthesizers, switch and source mux
  for (genvar c = 0; c < 2; c++)
  begin : g_core
    ccc_core_switch #(
      .STARTUP_SRC (c == 0 ? STARTUP_SRC0 : STARTUP_SRC1),
      .TWO_SPEED   (c == 0 ? TWO_SPEED0 : TWO_SPEED1)
    ) u_switch (
      .ref_clk       (ref_clk),
      .reset_n       (reset_n),
      .new_src       (ctrl_r[c][NEW_SRC_LSB +: 3]),
      .switch_set    (switch_set[c]),
      .pll_locked    (pll_lock[c]),
      .cur_src_r     (cur_src[c]),
      .pll_ref_src   (pll_ref_src[c]),
      .switch_flag_r (switch_flag[c]),
      .pll_enable    (pll_en[c]),
      .run_ok        (run_ok[c])
    );

    // primary pll reference follows the chosen pll source
    assign pll_ref_khz[c] = (pll_ref_src[c] == SRC_PRI_PLL) ? pri_khz
                          : rc_khz;

    ccc_synth u_pll (
      .ref_clk         (ref_clk),
      .reset_n         (reset_n),
      .enable          (pll_en[c]),
      .ref_khz         (pll_ref_khz[c]),
      .feedback_div    (pll_r[c][FB_LSB +: 8]),
      .input_prescaler (pll_r[c][PRE_LSB +: 4]),
      .first_postdiv   (pll_r[c][POST1_LSB +: 3]),
      .second_postdiv  (pll_r[c][POST2_LSB +: 3]),
      .vco_khz_r       (vco_khz[c]),
      .out_khz_r       (pll_khz[c]),
      .locked_r        (pll_lock[c])
    );

    ccc_synth u_aux (
      .ref_clk         (ref_clk),
      .reset_n         (reset_n),
      .enable          (aux_r[c][AUX_EN_BIT] & periph_clk_req[c]),
      .ref_khz         (rc_khz),
      .feedback_div    (aux_r[c][FB_LSB +: 8]),
      .input_prescaler (aux_r[c][PRE_LSB +: 4]),
      .first_postdiv   (aux_r[c][POST1_LSB +: 3]),
      .second_postdiv  (aux_r[c][POST2_LSB +: 3]),
      .vco_khz_r       (aux_vco_khz[c]),
      .out_khz_r       (aux_khz[c]),
      .locked_r        (aux_lock[c])
    );

    // system clock frequency of the running source
    always_comb
    begin
      case (cur_src[c])
        SRC_RC_DIV:    fosc_khz[c] = rc_khz >> ctrl_r[c][RC_DIV_LSB +: 3];
        SRC_RC_PLL,
        SRC_PRI_PLL:   fosc_khz[c] = pll_khz[c];
        SRC_PRI:       fosc_khz[c] = pri_khz;
        SRC_BACKUP_RC: fosc_khz[c] = 32'(BACKUP_RC_KHZ);
        SRC_SLOW_RC:   fosc_khz[c] = 32'(SLOW_RC_KHZ);
        default:       fosc_khz[c] = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus, instruction clocks and output pin
  always_comb
  begin
    logic [31:0] rd;
    logic        hit;
    logic [2:0]  ci;
    logic [7:0]  ro;
    rd          = 32'h0000_0000;
    hit         = 1'b0;
    ci          = 3'h0;
    ro          = 8'h00;
    ctrl_nxt    = ctrl_r;
    pll_nxt     = pll_r;
    aux_nxt     = aux_r;
    mode_nxt    = mode_r;
    trim_nxt    = trim_r;
    switch_set  = 2'b00;
    awready_nxt = 1'b0;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    arready_nxt = 1'b0;
    rvalid_nxt  = rvalid_r && !s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    // write: both channels taken together, one cycle after both valid
    if (s_axi_awvalid && s_axi_wvalid && !bvalid_r && !awready_r)
      awready_nxt = 1'b1;
    if (awready_r)
    begin
      ci  = s_axi_awaddr[7:5];
      ro  = {3'h0, s_axi_awaddr[4:0]};
      hit = 1'b1;
      if (ci < 3'h2)
      begin
        case (ro)
          OFS_OSC_CTRL:
          begin
            ctrl_nxt[ci[0]] = wmerge(ctrl_r[ci[0]], s_axi_wdata, s_axi_wstrb,
                                     CTRL_MASK);
            switch_set[ci[0]] = s_axi_wstrb[1] && s_axi_wdata[SWITCH_BIT];
          end
          OFS_PLL_CFG: pll_nxt[ci[0]] = wmerge(pll_r[ci[0]], s_axi_wdata,
                                               s_axi_wstrb, PLL_MASK);
          OFS_AUX_CFG: aux_nxt[ci[0]] = wmerge(aux_r[ci[0]], s_axi_wdata,
                                               s_axi_wstrb, AUX_MASK);
          OFS_FOSC_KHZ, OFS_FCY_KHZ, OFS_VCO_KHZ, OFS_AUX_KHZ: hit = 1'b1;
          default: hit = 1'b0;
        endcase
      end
      else if (s_axi_awaddr == OFS_OSC_MODE)
        mode_nxt = wmerge(mode_r, s_axi_wdata, s_axi_wstrb, MODE_MASK);
      else if (s_axi_awaddr == OFS_TRIM)
        trim_nxt = wmerge(trim_r, s_axi_wdata, s_axi_wstrb, TRIM_MASK);
      else
        hit = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = hit ? 2'b00 : 2'b10;
    end
    // read
    if (s_axi_arvalid && !rvalid_r && !arready_r)
      arready_nxt = 1'b1;
    if (arready_r)
    begin
      ci  = s_axi_araddr[7:5];
      ro  = {3'h0, s_axi_araddr[4:0]};
      hit = 1'b1;
      if (ci < 3'h2)
      begin
        case (ro)
          OFS_OSC_CTRL:
          begin
            rd = ctrl_r[ci[0]];
            rd[CUR_SRC_LSB +: 3] = cur_src[ci[0]];
            rd[SWITCH_BIT]       = switch_flag[ci[0]];
            rd[PLL_LOCK_BIT]     = pll_lock[ci[0]];
            rd[AUX_LOCK_BIT]     = aux_lock[ci[0]];
            rd[RUN_BIT]          = run_ok[ci[0]];
          end
          OFS_PLL_CFG:  rd = pll_r[ci[0]];
          OFS_AUX_CFG:  rd = aux_r[ci[0]];
          OFS_FOSC_KHZ: rd = fosc_khz[ci[0]];
          OFS_FCY_KHZ:  rd = fosc_khz[ci[0]] >> 1;
          OFS_VCO_KHZ:  rd = vco_khz[ci[0]];
          OFS_AUX_KHZ:  rd = aux_khz[ci[0]];
          default:      hit = 1'b0;
        endcase
      end
      else if (s_axi_araddr == OFS_OSC_MODE)
        rd = mode_r | (32'(pri_ok) << PRI_OK_BIT);
      else if (s_axi_araddr == OFS_TRIM)
        rd = trim_r;
      else
        hit = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt  = hit ? 2'b00 : 2'b10;
      rdata_nxt  = rd;
    end
    // instruction tick every second cycle of a running core
    run_nxt  = run_ok;
    tick_nxt = run_ok & ~tick_r;
    oe_nxt   = !crystal;
    pin_nxt  = !crystal && tick_r[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ctrl_r    <= '{CTRL_RST, CTRL_RST};
      pll_r     <= '{PLL_RST, PLL_RST};
      aux_r     <= '{PLL_RST, PLL_RST};
      mode_r    <= MODE_RST;
      trim_r    <= TRIM_RST;
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'b00;
      rdata_r   <= 32'h0000_0000;
      tick_r    <= 2'b00;
      run_r     <= 2'b00;
      pin_r     <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      pll_r     <= pll_nxt;
      aux_r     <= aux_nxt;
      mode_r    <= mode_nxt;
      trim_r    <= trim_nxt;
      awready_r <= awready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      tick_r    <= tick_nxt;
      run_r     <= run_nxt;
      pin_r     <= pin_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // outputs straight from flops
  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = awready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rresp       = rresp_r;
  assign s_axi_rdata       = rdata_r;
  assign core_instr_tick   = tick_r;
  assign core_run          = run_r;
  assign osc_output_pin_o  = pin_r;
  assign osc_output_pin_oe = oe_r;

endmodule : ccc_clock_ctrl
`default_nettype wire

// [ccc_pkg.sv]
package ccc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock sources and oscillator modes
  typedef enum logic [2:0] {
    SRC_RC_DIV    = 3'h0,
    SRC_RC_PLL    = 3'h1,
    SRC_PRI       = 3'h2,
    SRC_PRI_PLL   = 3'h3,
    SRC_BACKUP_RC = 3'h4,
    SRC_SLOW_RC   = 3'h5
  } ccc_src_t;

  typedef enum logic [1:0] {
    MODE_EXT_BYPASS = 2'h0,
    MODE_MED_XTAL   = 2'h1,
    MODE_HIGH_XTAL  = 2'h2,
    MODE_OFF        = 2'h3
  } ccc_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] OFS_OSC_CTRL  = 8'h00;
  localparam logic [7:0] OFS_PLL_CFG   = 8'h04;
  localparam logic [7:0] OFS_AUX_CFG   = 8'h08;
  localparam logic [7:0] OFS_FOSC_KHZ  = 8'h0C;
  localparam logic [7:0] OFS_FCY_KHZ   = 8'h10;
  localparam logic [7:0] OFS_VCO_KHZ   = 8'h14;
  localparam logic [7:0] OFS_AUX_KHZ   = 8'h18;
  localparam logic [7:0] CORE_STRIDE   = 8'h20;
  localparam logic [7:0] OFS_OSC_MODE  = 8'h40;
  localparam logic [7:0] OFS_TRIM      = 8'h44;

  // field positions
  localparam int NEW_SRC_LSB  = 0;
  localparam int CUR_SRC_LSB  = 4;
  localparam int SWITCH_BIT   = 8;
  localparam int PLL_LOCK_BIT = 12;
  localparam int AUX_LOCK_BIT = 13;
  localparam int RUN_BIT      = 14;
  localparam int RC_DIV_LSB   = 20;
  localparam int FB_LSB       = 0;
  localparam int PRE_LSB      = 8;
  localparam int POST1_LSB    = 12;
  localparam int POST2_LSB    = 16;
  localparam int AUX_EN_BIT   = 24;
  localparam int PRI_OK_BIT   = 8;

  // writable masks and reset values
  localparam logic [31:0] CTRL_MASK    = 32'h0070_0007;
  localparam logic [31:0] PLL_MASK     = 32'h0007_7FFF;
  localparam logic [31:0] AUX_MASK     = 32'h0107_7FFF;
  localparam logic [31:0] TRIM_MASK    = 32'h0000_003F;
  localparam logic [31:0] MODE_MASK    = 32'h0000_0003;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] PLL_RST      = 32'h0001_4132;
  localparam logic [31:0] MODE_RST     = 32'h0000_0000;
  localparam logic [31:0] TRIM_RST     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator figures in kHz
  localparam int RC_KHZ        = 8000;
  localparam int BACKUP_RC_KHZ = 8000;
  localparam int SLOW_RC_KHZ   = 32;
  localparam int TRIM_STEP_KHZ = 30;
  localparam int MED_MIN_KHZ   = 3500;
  localparam int MED_MAX_KHZ   = 10000;
  localparam int HIGH_MIN_KHZ  = 10000;
  localparam int HIGH_MAX_KHZ  = 32000;
  localparam int EXT_MAX_KHZ   = 64000;
  localparam int PRI_KHZ       = 10000;

  // timing
  localparam int CLK_MHZ         = 125;
  localparam int PLL_LOCK_NS     = 10000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;

  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == SRC_RC_PLL) || (s == SRC_PRI_PLL);
  endfunction : is_pll

endpackage : ccc_pkg

// [ccc_synth.sv]
`timescale 1ns/100ps
`default_nettype none
module ccc_synth
  import ccc_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        enable,
  input  wire logic [31:0] ref_khz,
  input  wire logic [7:0]  feedback_div,
  input  wire logic [3:0]  input_prescaler,
  input  wire logic [2:0]  first_postdiv,
  input  wire logic [2:0]  second_postdiv,
  // status
  output logic      [31:0] vco_khz_r,
  output logic      [31:0] out_khz_r,
  output logic             locked_r
);

  logic [31:0] vco_khz_nxt;
  logic [31:0] out_khz_nxt;
  logic        locked_nxt;
  logic [15:0] lock_cnt_r;
  logic [15:0] lock_cnt_nxt;
  logic [17:0] cfg_r;
  logic [17:0] cfg_nxt;
  logic [31:0] num;
  logic [9:0]  den;

  ////////////////////////////////////////////////////////////////////////////
  // frequency relations and lock timer
  always_comb
  begin
    cfg_nxt     = {feedback_div, input_prescaler, first_postdiv, second_postdiv};
    num         = ref_khz * {24'h00_0000, feedback_div};
    den         = 10'(input_prescaler * first_postdiv * second_postdiv);
    vco_khz_nxt = (input_prescaler == 4'h0) ? 32'h0000_0000
                : num / {28'h000_0000, input_prescaler};
    out_khz_nxt = (den == 10'h000) ? 32'h0000_0000
                : num / {22'h00_0000, den};
    lock_cnt_nxt = lock_cnt_r;
    locked_nxt   = locked_r;
    if (!enable || cfg_nxt != cfg_r)   // relock after any divider change
    begin
      lock_cnt_nxt = 16'h0000;
      locked_nxt   = 1'b0;
    end
    else if (lock_cnt_r == 16'(LOCK_CYCLES - 1))
      locked_nxt = 1'b1;
    else
      lock_cnt_nxt = lock_cnt_r + 16'h0001;
    if (!enable)
    begin
      vco_khz_nxt = 32'h0000_0000;
      out_khz_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      vco_khz_r  <= 32'h0000_0000;
      out_khz_r  <= 32'h0000_0000;
      locked_r   <= 1'b0;
      lock_cnt_r <= 16'h0000;
      cfg_r      <= 18'h0_0000;
    end
    else
    begin
      vco_khz_r  <= vco_khz_nxt;
      out_khz_r  <= out_khz_nxt;
      locked_r   <= locked_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      cfg_r      <= cfg_nxt;
    end
  end

endmodule : ccc_synth
`default_nettype wire

// [ccc_core_switch.sv]
`timescale 1ns/100ps
`default_nettype none
module ccc_core_switch
  import ccc_pkg::*;
#(
  parameter logic [2:0] STARTUP_SRC = SRC_RC_DIV,
  parameter bit         TWO_SPEED   = 1'b0
)(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // software request and pll lock
  input  wire logic [2:0] new_src,
  input  wire logic       switch_set,
  input  wire logic       pll_locked,
  // state
  output logic      [2:0] cur_src_r,
  output logic      [2:0] pll_ref_src,
  output logic            switch_flag_r,
  output logic            pll_enable,
  output logic            run_ok
);

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_WAIT = 2'h1
  } ccc_sw_t;

  ccc_sw_t    state_r;
  ccc_sw_t    state_nxt;
  logic [2:0] cur_nxt;
  logic [2:0] tgt_r;
  logic [2:0] tgt_nxt;
  logic       flag_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_src_r;
    tgt_nxt   = tgt_r;
    flag_nxt  = switch_flag_r;
    case (state_r)
      SW_IDLE:
      begin
        if (switch_flag_r)
        begin
          if (new_src == cur_src_r || new_src > SRC_SLOW_RC)
            flag_nxt = 1'b0;                       // nothing to do
          else if (is_pll(new_src) && is_pll(cur_src_r))
            flag_nxt = 1'b0;
          else if (is_pll(new_src))
          begin
            tgt_nxt   = new_src;
            state_nxt = SW_WAIT;
          end
          else
          begin
            cur_nxt  = new_src;
            flag_nxt = 1'b0;
          end
        end
      end
      SW_WAIT:
      begin
        if (pll_locked)
        begin
          cur_nxt   = tgt_r;
          flag_nxt  = 1'b0;
          state_nxt = SW_IDLE;
        end
      end
      default:
        state_nxt = SW_IDLE;
    endcase
    if (switch_set && state_r == SW_IDLE)
      flag_nxt = 1'b1;
  end

  // pll runs for the running or the awaited source
  always_comb
  begin
    pll_ref_src = (state_r == SW_WAIT) ? tgt_r : cur_src_r;
    pll_enable  = is_pll(cur_src_r) || state_r == SW_WAIT;
    run_ok      = !is_pll(cur_src_r) || pll_locked;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      if (TWO_SPEED && is_pll(STARTUP_SRC))
      begin
        cur_src_r <= SRC_RC_DIV;
        state_r   <= SW_WAIT;
      end
      else
      begin
        cur_src_r <= STARTUP_SRC;
        state_r   <= SW_IDLE;
      end
      tgt_r         <= STARTUP_SRC;
      switch_flag_r <= 1'b0;
    end
    else
    begin
      cur_src_r     <= cur_nxt;
      state_r       <= state_nxt;
      tgt_r         <= tgt_nxt;
      switch_flag_r <= flag_nxt;
    end
  end

endmodule : ccc_core_switch
`default_nettype wire

// [ccc_osc_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ccc_osc_pin_model (
  // oscillator output pin as seen from the board
  input  wire logic pin,
  input  wire logic pin_oe,
  // observed instruction clock cycles
  output int        pulses
);
  // counts rising edges only while the pin is driven
  initial pulses = 0;
  always @(posedge pin)
    if (pin_oe)
      pulses++;
endmodule : ccc_osc_pin_model
`default_nettype wire

// [ccc_clock_ctrl_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module ccc_clock_ctrl_sva
  import ccc_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // core clocks and pin
  input wire logic [1:0]  core_instr_tick,
  input wire logic [1:0]  core_run,
  input wire logic        osc_output_pin_o,
  input wire logic        osc_output_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // one idle cycle, then the next tick unless the core stopped
  sequence tick_gap;
    !core_instr_tick[0] ##1 (core_instr_tick[0] || !core_run[0]);
  endsequence
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
    else $error("write readies split");
  a_write_resp: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
    else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_resp: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_tick_half: assert property (core_instr_tick[0] |=> tick_gap)
    else $error("tick not half rate");
  a_tick_run: assert property (core_instr_tick[1] |->
    core_run[1] && !$past(core_instr_tick[1]))
    else $error("tick without run");
  a_pin_oe: assert property (osc_output_pin_o |-> osc_output_pin_oe)
    else $error("pin toggles undriven");
endmodule : ccc_clock_ctrl_sva
bind ccc_clock_ctrl ccc_clock_ctrl_sva u_sva (.*);
`default_nettype wire

// [ccc_clock_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module ccc_clock_ctrl_test
  import ccc_pkg::*;
;
  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, core_instr_tick, core_run, rsp;
  logic [1:0]  periph_clk_req = 2'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        osc_output_pin_o, osc_output_pin_oe;
  int          n_fail = 0, checks_done = 0, cyc = 0, pulses, p0;
  logic [2:0]  srcs [4] = '{SRC_PRI, SRC_BACKUP_RC, SRC_SLOW_RC, SRC_RC_DIV};
  int          frq  [4] = '{PRI_KHZ, BACKUP_RC_KHZ, SLOW_RC_KHZ, RC_KHZ};

  ccc_clock_ctrl #(.STARTUP_SRC1(SRC_RC_PLL), .TWO_SPEED1(1'b1))
    uut (.*);
  ccc_osc_pin_model u_pin (.pin(osc_output_pin_o), .pin_oe(osc_output_pin_oe),
                           .pulses(pulses));

  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  // bus master tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // wait for the switch flag to clear
  task automatic poll(input logic [7:0] a);
    do axr(a); while (rd[SWITCH_BIT] === 1'b1);
  endtask : poll
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    axr(OFS_PLL_CFG); `CHK("pll reset", PLL_RST, rd)
    axr(8'h48); `CHK("bad read", 34'h2_0000_0000, {rsp, rd})
    axw(8'h48, 32'hFFFF_FFFF); `CHK("bad write", 2'h2, rsp)
    $display("reset test done");
    axw(OFS_PLL_CFG, 32'h0001_517D);
    axw(OFS_OSC_CTRL, 32'h0000_0101);
    axr(OFS_OSC_CTRL); `CHK("flag", 1'b1, rd[SWITCH_BIT])
    poll(OFS_OSC_CTRL); `CHK("src", 3'h1, rd[CUR_SRC_LSB +: 3])
    axr(OFS_VCO_KHZ); `CHK("vco", RC_KHZ * 125, rd)
    axr(OFS_FOSC_KHZ); `CHK("fosc", RC_KHZ * 125 / 5, rd)
    axr(OFS_FCY_KHZ); `CHK("fcy", RC_KHZ * 125 / 10, rd)
    axw(OFS_OSC_CTRL, 32'h0000_0103);
    poll(OFS_OSC_CTRL); `CHK("pll pll", 3'h1, rd[CUR_SRC_LSB +: 3])
    axr(CORE_STRIDE); `CHK("two speed", 3'h1, rd[CUR_SRC_LSB +: 3])
    `CHK("run", 2'b11, core_run)
    $display("pll test done");
    foreach (srcs[i])
    begin
      axw(CORE_STRIDE, 32'h0000_0100 | 32'(srcs[i]));
      poll(CORE_STRIDE); `CHK("src1", srcs[i], rd[CUR_SRC_LSB +: 3])
      axr(CORE_STRIDE + OFS_FOSC_KHZ); `CHK("fosc1", frq[i], rd)
    end
    $display("source test done");
    axw(CORE_STRIDE + OFS_AUX_CFG, 32'h0101_517D);
    repeat (PLL_LOCK_CYCLES + 20) @(posedge ref_clk);
    axr(CORE_STRIDE); `CHK("aux idle", 1'b0, rd[AUX_LOCK_BIT])
    periph_clk_req <= 2'h2;
    repeat (PLL_LOCK_CYCLES + 20) @(posedge ref_clk);
    axr(CORE_STRIDE); `CHK("aux lock", 1'b1, rd[AUX_LOCK_BIT])
    axr(CORE_STRIDE + OFS_AUX_KHZ); `CHK("aux", RC_KHZ * 125 / 5, rd)
    axr(OFS_OSC_CTRL); `CHK("aux0", 1'b0, rd[AUX_LOCK_BIT])
    $display("aux test done");
    for (int m = 0; m < 4; m++)
    begin
      axw(OFS_OSC_MODE, 32'(m));
      repeat (2) @(posedge ref_clk);
      `CHK("pin oe", m == 0 || m == 3, osc_output_pin_oe)
      axr(OFS_OSC_MODE);
      `CHK("mode", 32'(m) | (32'(m < 3) << PRI_OK_BIT), rd)
    end
    p0 = pulses;
    repeat (20) @(posedge ref_clk);
    `CHK("pin ticks", 1'b1, pulses > p0)
    axw(OFS_TRIM, 32'h0000_0001);
    axr(CORE_STRIDE + OFS_FOSC_KHZ); `CHK("trim", RC_KHZ + TRIM_STEP_KHZ, rd)
    $display("pin and trim test done");
    close_out();
  end
endmodule : ccc_clock_ctrl_test
`default_nettype wire
